// ==== design/cpu_test_transfer_wait_ops.sv ====
/*
 * executes the test, flag/index/stack transfer and wait instructions,
 * holding accumulator, index pair, stack pointer and flags.
 * assumes the fetch unit offers one decoded opcode at a time, and an
 * asynchronous-read internal bus that answers in the cycle addressed.
 * irq_i comes from interrupt logic on this same clock.
 */
`default_nettype none
// Notes on behaviour
// - test subtracts zero, stores nothing, clears V, sets N Z, keeps H C.
// - test opcodes 3d,4d,5d,6d,7d,9e6d take 3,1,1,3,2,4 cycles.
// - wait opcode 8f clears interrupt mask only, fetch in one cycle.
// - after wait, instruction clocking stops until an interrupt arrives.
module cpu_test_transfer_wait_ops
	import cpu_ops_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	input  wire logic        issue_i,
	input  wire logic        prefix_i,
	input  wire logic [7:0]  opcode_i,
	input  wire logic [7:0]  operand_i,
	input  wire logic [7:0]  mem_data_i,
	input  wire logic        irq_i,
	output logic             ready_o,
	output logic             mem_rd_o,
	output logic      [15:0] mem_addr_o,
	output logic             cpu_clk_run_o,
	output logic      [7:0]  acc_o,
	output logic      [15:0] index_o,
	output logic      [15:0] sp_o,
	output logic      [7:0]  flags_o
);
	state_e      st_q;
	kind_e       kind_q;
	kind_e       dec_kind;
	logic [2:0]  cnt_q;
	logic [2:0]  dec_cycles;
	logic [15:0] dec_addr;
	logic [15:0] addr_q;
	logic [7:0]  acc_q;
	logic [15:0] hx_q;
	logic [15:0] sp_q;
	logic [7:0]  flags_q;
	logic        take;
	logic        last;
	kind_e       commit_kind;
	logic        commit;

	flag_calc_if fc ();

	test_flag_calc u_calc (
		.fc (fc)
	);

	always_comb begin
		dec_kind   = K_NONE;
		dec_cycles = CYC_ONE;
		dec_addr   = ADDR_RESET;
		if (prefix_i) begin
			if (opcode_i == OP_TEST_SP_OFS) begin
				dec_kind   = K_TEST_M;
				dec_cycles = CYC_TEST_SP_OFS;
				dec_addr   = sp_q + {ZERO_BYTE, operand_i};
			end
		end else begin
			case (opcode_i)
				OP_TEST_DIR: begin
					dec_kind   = K_TEST_M;
					dec_cycles = CYC_TEST_DIR;
					dec_addr   = {DIRECT_PAGE, operand_i};
				end
				OP_TEST_ACC: dec_kind = K_TEST_A;
				OP_TEST_IDX: dec_kind = K_TEST_X;
				OP_TEST_IDX_OFS: begin
					dec_kind   = K_TEST_M;
					dec_cycles = CYC_TEST_IDX_OFS;
					dec_addr   = hx_q + {ZERO_BYTE, operand_i};
				end
				OP_TEST_IDX_PTR: begin
					dec_kind   = K_TEST_M;
					dec_cycles = CYC_TEST_IDX_PTR;
					dec_addr   = hx_q;
				end
				OP_COPY_FLAGS: dec_kind = K_FLAGS_TO_A;
				OP_COPY_INDEX: dec_kind = K_INDEX_TO_A;
				OP_SP_TO_INDEX: begin
					dec_kind   = K_SP_TO_INDEX;
					dec_cycles = CYC_XFER2;
				end
				OP_INDEX_TO_SP: begin
					dec_kind   = K_INDEX_TO_SP;
					dec_cycles = CYC_XFER2;
				end
				OP_WAIT: dec_kind = K_WAIT;
				default: dec_kind = K_NONE;
			endcase
		end
	end

	// unknown opcodes are swallowed in one cycle; other groups decode them
	assign ready_o       = (st_q == ST_IDLE);
	assign take          = clk_en_i && issue_i && ready_o;
	assign last          = (st_q == ST_EXEC) && (cnt_q == CYC_ONE);
	assign mem_rd_o      = (st_q == ST_EXEC) && (kind_q == K_TEST_M);
	assign cpu_clk_run_o = (st_q != ST_WAIT);
	assign commit        = clk_en_i && ((take && dec_cycles == CYC_ONE)
	                       || last);
	assign commit_kind   = last ? kind_q : dec_kind;
	// memory data is only read on the finishing edge of a memory test
	assign fc.value      = (commit_kind == K_TEST_M) ? mem_data_i :
	                       (commit_kind == K_TEST_X) ? hx_q[7:0] : acc_q;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_q  <= ST_IDLE;
			cnt_q <= CYC_ZERO;
		end else if (clk_en_i) begin
			case (st_q)
				ST_IDLE: begin
					if (issue_i && dec_kind == K_WAIT) begin
						st_q <= ST_WAIT;
					end else if (issue_i && dec_cycles != CYC_ONE) begin
						st_q  <= ST_EXEC;
						cnt_q <= dec_cycles - CYC_ONE;
					end
				end
				ST_EXEC: begin
					if (cnt_q == CYC_ONE) begin
						st_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - CYC_ONE;
					end
				end
				ST_WAIT: begin
					if (irq_i) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			kind_q <= K_NONE;
			addr_q <= ADDR_RESET;
		end else if (take) begin
			kind_q <= dec_kind;
			addr_q <= dec_addr;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			acc_q   <= ACC_RESET;
			hx_q    <= INDEX_RESET;
			sp_q    <= SP_RESET;
			flags_q <= FLAGS_RESET;
		end else if (commit) begin
			case (commit_kind)
				K_TEST_A, K_TEST_X, K_TEST_M: begin
					flags_q[FLAG_V] <= 1'b0;
					flags_q[FLAG_N] <= fc.neg;
					flags_q[FLAG_Z] <= fc.zero;
				end
				K_FLAGS_TO_A:  acc_q <= flags_q;
				K_INDEX_TO_A:  acc_q <= hx_q[7:0];
				K_SP_TO_INDEX: hx_q  <= sp_q + STEP_ONE;
				K_INDEX_TO_SP: sp_q  <= hx_q - STEP_ONE;
				K_WAIT:  flags_q[FLAG_I] <= 1'b0;
				default: acc_q <= acc_q;
			endcase
		end
	end

	assign mem_addr_o = addr_q;
	assign acc_o      = acc_q;
	assign index_o    = hx_q;
	assign sp_o       = sp_q;
	assign flags_o    = flags_q;

	// assertions assume clk_en_i stays high across the watched window
	logic take_op;
	assign take_op = take && !prefix_i;

	a_test_acc_flags: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_TEST_ACC |=> !flags_o[FLAG_V]
		&& flags_o[FLAG_Z] == ($past(acc_o) == ZERO_BYTE)
		&& flags_o[FLAG_N] == $past(acc_o[7])
		&& acc_o == $past(acc_o))
		else $error("test of accumulator set wrong flags");

	a_test_keeps_hc: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_TEST_DIR |-> ##3
		flags_o[FLAG_H] == $past(flags_o[FLAG_H], 3)
		&& flags_o[FLAG_C] == $past(flags_o[FLAG_C], 3))
		else $error("test changed half-carry or carry");

	a_test_dir_len: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_TEST_DIR |=>
		!ready_o [*2] ##1 ready_o)
		else $error("direct test not three cycles");

	a_test_sp_len: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take && prefix_i && opcode_i == OP_TEST_SP_OFS |=>
		!ready_o [*3] ##1 ready_o)
		else $error("stack offset test not four cycles");

	a_wait_mask: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_WAIT |=> !flags_o[FLAG_I]
		&& (flags_o | FLAG_I_MASK) == ($past(flags_o) | FLAG_I_MASK))
		else $error("wait did not clear only the mask");

	a_wait_hold: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		!cpu_clk_run_o && !irq_i |=> !cpu_clk_run_o && !ready_o)
		else $error("wait left without an interrupt");

	a_wait_wake: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		!cpu_clk_run_o && irq_i |=> cpu_clk_run_o && ready_o)
		else $error("interrupt did not end wait");

	a_sp_to_index: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_SP_TO_INDEX |-> ##2 ready_o
		&& index_o == $past(sp_o, 2) + STEP_ONE
		&& flags_o == $past(flags_o, 2))
		else $error("stack to index transfer wrong");

	a_index_to_sp: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i || !clk_en_i)
		take_op && opcode_i == OP_INDEX_TO_SP |-> ##2
		sp_o == $past(index_o, 2) - STEP_ONE
		&& flags_o == $past(flags_o, 2))
		else $error("index to stack transfer wrong");

	c_test_mem: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) last && kind_q == K_TEST_M);
	c_test_sp_ofs: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) take && prefix_i
		&& opcode_i == OP_TEST_SP_OFS);
	c_wait_wake: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) !cpu_clk_run_o ##1 cpu_clk_run_o);
	c_copy_flags: cover property (@(posedge clk_sys_i)
		disable iff (!rst_n_i) take_op && opcode_i == OP_COPY_FLAGS);
endmodule : cpu_test_transfer_wait_ops
`default_nettype wire

// ==== inc/cpu_ops_pkg.sv ====
/*
 * constants for the test, transfer and wait instruction group:
 * opcodes, cycle counts, flag bit positions and reset values.
 * assumes an 8-bit core with a 16-bit address space.
 */
`default_nettype none
package cpu_ops_pkg;
	localparam logic [7:0] OP_PREFIX        = 8'h9e;
	localparam logic [7:0] OP_TEST_DIR      = 8'h3d;
	localparam logic [7:0] OP_TEST_ACC      = 8'h4d;
	localparam logic [7:0] OP_TEST_IDX      = 8'h5d;
	localparam logic [7:0] OP_TEST_IDX_OFS  = 8'h6d;
	localparam logic [7:0] OP_TEST_IDX_PTR  = 8'h7d;
	localparam logic [7:0] OP_TEST_SP_OFS   = 8'h6d;
	localparam logic [7:0] OP_COPY_FLAGS    = 8'h85;
	localparam logic [7:0] OP_COPY_INDEX    = 8'h9f;
	localparam logic [7:0] OP_SP_TO_INDEX   = 8'h95;
	localparam logic [7:0] OP_INDEX_TO_SP   = 8'h94;
	localparam logic [7:0] OP_WAIT          = 8'h8f;

	localparam logic [2:0] CYC_ONE          = 3'h1;
	localparam logic [2:0] CYC_TEST_DIR     = 3'h3;
	localparam logic [2:0] CYC_TEST_IDX_OFS = 3'h3;
	localparam logic [2:0] CYC_TEST_IDX_PTR = 3'h2;
	localparam logic [2:0] CYC_TEST_SP_OFS  = 3'h4;
	localparam logic [2:0] CYC_XFER2        = 3'h2;
	localparam logic [2:0] CYC_ZERO         = 3'h0;

	localparam int FLAG_V = 7;
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;

	localparam logic [7:0]  TEST_SUBTRAHEND = 8'h00;
	localparam logic [7:0]  DIRECT_PAGE     = 8'h00;
	localparam logic [7:0]  FLAGS_RESET     = 8'h68;
	localparam logic [7:0]  ACC_RESET       = 8'h00;
	localparam logic [15:0] INDEX_RESET     = 16'h0000;
	localparam logic [15:0] SP_RESET        = 16'h00ff;
	localparam logic [15:0] ADDR_RESET      = 16'h0000;
	localparam logic [15:0] STEP_ONE        = 16'h0001;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [7:0]  FLAG_I_MASK     = 8'h08;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WAIT = 2'b10
	} state_e;

	typedef enum logic [3:0] {
		K_NONE        = 4'b0000,
		K_TEST_A      = 4'b0001,
		K_TEST_X      = 4'b0010,
		K_TEST_M      = 4'b0011,
		K_FLAGS_TO_A  = 4'b0100,
		K_INDEX_TO_A  = 4'b0101,
		K_SP_TO_INDEX = 4'b0110,
		K_INDEX_TO_SP = 4'b0111,
		K_WAIT        = 4'b1000
	} kind_e;
endpackage : cpu_ops_pkg
`default_nettype wire

// ==== inc/flag_calc_if.sv ====
/*
 * carrier between the executor and the negative/zero evaluator.
 * assumes both ends share one clock; it carries no state.
 */
`default_nettype none
interface flag_calc_if;
	logic [7:0] value;
	logic       neg;
	logic       zero;
	modport calc (input value, output neg, output zero);
	modport user (output value, input neg, input zero);
endinterface : flag_calc_if
`default_nettype wire

// ==== design/test_flag_calc.sv ====
/*
 * negative and zero evaluation of an operand minus zero.
 * assumes the operand is stable for the whole cycle it is read in.
 */
`default_nettype none
module test_flag_calc
	import cpu_ops_pkg::*;
(
	flag_calc_if.calc fc
);
	logic [7:0] diff;

	// result is thrown away; only the flags leave this module
	assign diff    = fc.value - TEST_SUBTRAHEND;
	assign fc.neg  = diff[7];
	assign fc.zero = (diff == ZERO_BYTE);
endmodule : test_flag_calc
`default_nettype wire

// ==== verif/test_cpu_test_transfer_wait_ops.sv ====
/*
 * self-checking bench for the test, transfer and wait executor.
 * assumes the bench alone drives the instruction, bus and irq inputs.
 */
`default_nettype none
`define CHK(got, exp, msg) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("mismatch at %0t: %s", $time, msg); \
	end \
end
module test_cpu_test_transfer_wait_ops
	import cpu_ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        clk_en_i = 1'b1;
	logic        issue_i = 1'b0;
	logic        prefix_i = 1'b0;
	logic [7:0]  opcode_i = 8'h00;
	logic [7:0]  operand_i = 8'h00;
	logic [7:0]  mem_data_i = 8'h00;
	logic        irq_i = 1'b0;
	logic        ready_o, mem_rd_o, cpu_clk_run_o;
	logic [15:0] mem_addr_o, index_o, sp_o, e_idx, e_sp;
	logic [7:0]  acc_o, flags_o, e_acc, e_flg;
	int          num_errors = 0;
	int          n_compared = 0;
	integer      seed = 28830;
	// slot 10 is prefix with the accumulator test byte: swallowed in one cycle
	localparam logic [7:0] OPC [11] = '{OP_TEST_DIR, OP_TEST_ACC,
		OP_TEST_IDX, OP_TEST_IDX_OFS, OP_TEST_IDX_PTR, OP_TEST_SP_OFS,
		OP_COPY_FLAGS, OP_COPY_INDEX, OP_SP_TO_INDEX, OP_INDEX_TO_SP,
		OP_TEST_ACC};
	localparam int CYC [11] = '{3, 1, 1, 3, 2, 4, 1, 1, 2, 2, 1};
	localparam logic [7:0] CORN [3] = '{8'h80, 8'h00, 8'h7f};

	cpu_test_transfer_wait_ops dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .issue_i(issue_i), .prefix_i(prefix_i),
		.opcode_i(opcode_i), .operand_i(operand_i), .mem_data_i(mem_data_i),
		.irq_i(irq_i), .ready_o(ready_o), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .cpu_clk_run_o(cpu_clk_run_o),
		.acc_o(acc_o), .index_o(index_o), .sp_o(sp_o), .flags_o(flags_o));

	always #50 clk_sys_i = ~clk_sys_i;

	function automatic logic [7:0] test_flags(input logic [7:0] f, v);
		return {1'b0, f[6:3], v[7], v == 8'h00, f[0]};
	endfunction : test_flags

	function automatic logic [15:0] eff_addr(input int k, logic [7:0] opr);
		case (k)
			0: return {8'h00, opr};
			3: return e_idx + {8'h00, opr};
			4: return e_idx;
			5: return e_sp + {8'h00, opr};
			default: return 16'h0000;
		endcase
	endfunction : eff_addr

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	task automatic end_test(input string name);
		$display("end of test %s, mismatches so far %0d", name, num_errors);
	endtask : end_test

	task automatic chk_state();
		`CHK(acc_o, e_acc, "accumulator")
		`CHK(index_o, e_idx, "index pair")
		`CHK(sp_o, e_sp, "stack pointer")
		`CHK(flags_o, e_flg, "flags")
	endtask : chk_state

	task automatic do_reset(input int n);
		rst_n_i = 1'b0;
		repeat (n) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		e_acc = ACC_RESET;
		e_idx = INDEX_RESET;
		e_sp = SP_RESET;
		e_flg = FLAGS_RESET;
		`CHK(ready_o, 1'b1, "ready after reset")
		`CHK(cpu_clk_run_o, 1'b1, "running after reset")
		`CHK(mem_rd_o, 1'b0, "no read after reset")
		`CHK(mem_addr_o, ADDR_RESET, "address after reset")
		chk_state();
	endtask : do_reset

	// 1-cycle ops keep issue up so the next op goes back to back
	task automatic do_op(input int k, input logic [7:0] opr, md);
		logic [15:0] ea;
		ea = eff_addr(k, opr);
		issue_i = 1'b1;
		prefix_i = (k == 5 || k == 10);
		opcode_i = OPC[k];
		operand_i = opr;
		mem_data_i = md;
		@(posedge clk_sys_i);
		#1;
		if (CYC[k] > 1)
			issue_i = 1'b0;
		`CHK(ready_o, 1'(CYC[k] == 1), "ready after take")
		if (k == 0 || (k >= 3 && k <= 5)) begin
			`CHK(mem_rd_o, 1'b1, "read strobe")
			`CHK(mem_addr_o, ea, "operand address")
		end
		if (CYC[k] > 1) begin
			repeat (CYC[k] - 1) @(posedge clk_sys_i);
			#1;
		end
		`CHK(ready_o, 1'b1, "ready at end")
		`CHK(mem_rd_o, 1'b0, "read strobe off")
		case (k)
			0, 3, 4, 5: e_flg = test_flags(e_flg, md);
			1: e_flg = test_flags(e_flg, e_acc);
			2: e_flg = test_flags(e_flg, e_idx[7:0]);
			6: e_acc = e_flg;
			7: e_acc = e_idx[7:0];
			8: e_idx = e_sp + 16'h0001;
			9: e_sp = e_idx - 16'h0001;
			default: ;
		endcase
		chk_state();
	endtask : do_op

	// a held issue while waiting must be ignored
	task automatic do_wait();
		issue_i = 1'b1;
		prefix_i = 1'b0;
		opcode_i = OP_WAIT;
		@(posedge clk_sys_i);
		#1;
		opcode_i = OP_COPY_INDEX;
		e_flg[FLAG_I] = 1'b0;
		`CHK(flags_o, e_flg, "mask cleared")
		`CHK(cpu_clk_run_o, 1'b0, "clocking stopped")
		`CHK(ready_o, 1'b0, "busy while waiting")
		repeat (4) @(posedge clk_sys_i);
		#1;
		`CHK(cpu_clk_run_o, 1'b0, "still stopped")
		issue_i = 1'b0;
		irq_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		irq_i = 1'b0;
		`CHK(cpu_clk_run_o, 1'b1, "resumed on irq")
		`CHK(ready_o, 1'b1, "ready on irq")
		chk_state();
	endtask : do_wait

	initial begin
		int i;
		int k;
		do_reset(20);
		end_test("reset");
		do_wait();
		end_test("wait");
		for (i = 0; i < 3; i++)
			for (k = 0; k < 11; k++)
				do_op(k, 8'($random(seed)), CORN[i]);
		issue_i = 1'b0;
		end_test("directed");
		repeat (60) begin
			k = $unsigned($random(seed)) % 11;
			do_op(k, 8'($random(seed)), 8'($random(seed)));
		end
		issue_i = 1'b0;
		end_test("random");
		@(posedge clk_sys_i);
		#1;
		clk_en_i = 1'b0;
		issue_i = 1'b1;
		prefix_i = 1'b0;
		opcode_i = OP_SP_TO_INDEX;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`CHK(ready_o, 1'b1, "frozen while disabled")
		chk_state();
		issue_i = 1'b0;
		clk_en_i = 1'b1;
		end_test("clock enable");
		do_reset(2);
		do_wait();
		end_test("second reset");
		give_verdict();
	end

	// run is about 220 cycles; allow about nine times that
	initial begin
		#200000;
		num_errors++;
		$display("watchdog expired at %0t", $time);
		give_verdict();
	end
endmodule : test_cpu_test_transfer_wait_ops
`default_nettype wire
